// ---- hw/mic_bias_diag_cfg.svh ----
// Offsets, field positions and reset values of the bias diagnostic registers
// Assumes an 8-bit register address and 8-bit register data
`ifndef MIC_BIAS_DIAG_CFG_SVH
`define MIC_BIAS_DIAG_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define BIAS_FAULT_LATCH_ADDR   8'h37
`define BIAS_HIGH_LIMIT_ADDR    8'h38
`define BIAS_LOW_LIMIT_ADDR     8'h39

// ****************************************************************
// Reset values
// ****************************************************************
`define BIAS_FAULT_LATCH_RST    8'h00
`define BIAS_HIGH_LIMIT_RST     8'hba
`define BIAS_LOW_LIMIT_RST      8'h4b

// ****************************************************************
// Fault latch field positions
// ****************************************************************
`define FLT_HIGH_BIT            7
`define FLT_LOW_BIT             6
`define FLT_OV_BIT              5
`define FLT_RSVD_MSB            4
`define FLT_RSVD_LSB            0

// ****************************************************************
// Threshold code scale, current in units of 0.01 mA
// ****************************************************************
`define THR_CODE_MIN            8'h39
`define THR_CODE_MAX            8'hf2
`define THR_STEP_CENTI_MA       14'h0036
`define THR_MAX_CENTI_MA        14'h2706

`endif

// ---- hw/mic_bias_diag_pkg.sv ----
// Types shared by the bias diagnostic register bank
// Assumes the constants of mic_bias_diag_cfg.svh
package mic_bias_diag_pkg;

  // ****************************************************************
  // Register port carriers
  // ****************************************************************
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_t;

  // ****************************************************************
  // Fault events, ordered as the latch bits 7..5
  // ****************************************************************
  typedef struct packed {
    logic high;
    logic low;
    logic ov;
  } fault_vec_t;

  typedef struct packed {
    logic flag;
  } flag_state_t;

  typedef struct packed {
    logic [7:0]  hi_thr;
    logic [7:0]  lo_thr;
    logic [13:0] hi_centi;
    logic [13:0] lo_centi;
    reg_rsp_t    rsp;
  } bank_state_t;

endpackage : mic_bias_diag_pkg

// ---- hw/fault_flag_cell.sv ----
// One sticky fault flag, set by a detector event, cleared by a read
// Assumes event and clear are synchronous one-cycle levels on clk_i
`timescale 1ns/1ps
module fault_flag_cell (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic event_i,
  input  wire logic clear_i,
  output logic      flag_o
);
  import mic_bias_diag_pkg::*;

  flag_state_t state_q;
  flag_state_t state_d;

  // ****************************************************************
  // Set wins over clear
  // ****************************************************************
  always_comb begin
    state_d      = state_q;
    state_d.flag = event_i | (state_q.flag & ~clear_i);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flag_o = state_q.flag;

  AST_FLAG_HOLDS: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q.flag && !clear_i) |=> state_q.flag)
    else $error("Fault flag dropped without a read");

  AST_EVENT_KEPT: assert property (@(posedge clk_i) disable iff (reset_i)
    (event_i && clear_i) |=> state_q.flag)
    else $error("Fault event lost during read clear");

endmodule : fault_flag_cell

// ---- hw/mic_bias_load_fault_diag.sv ----
// Bias supply load-current and over-voltage fault register bank
// Assumes register requests, measurements and detector levels are synchronous
`timescale 1ns/1ps
`include "mic_bias_diag_cfg.svh"

// Function
// - Latch bit 7 reads 1 after a high load current fault, self-clearing.
// - Latch bit 6 reads 1 after a low load current fault, self-clearing.
// - Latch bit 5 reads 1 after a bias over-voltage fault, self-clearing.
// - Latch bits 4..0 read zero; software writes only zeros there.
// - High threshold code 57 is 0 mA, plus 0.54 mA per code, 242 is 99.90 mA.
// - High threshold resets to code 186, about 69.66 mA.
// - Low threshold code 57 is 0 mA, plus 0.54 mA per code, 242 is 99.90 mA.
// - Low threshold resets to code 75, about 9.72 mA.
module mic_bias_load_fault_diag (
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  input  wire mic_bias_diag_pkg::reg_req_t   req_i,
  output mic_bias_diag_pkg::reg_rsp_t        rsp_o,
  input  wire logic                          meas_valid_i,
  input  wire logic [7:0]                    meas_code_i,
  input  wire logic                          ov_detect_i,
  output logic [7:0]                         hi_thr_o,
  output logic [7:0]                         lo_thr_o,
  output logic [13:0]                        hi_centi_ma_o,
  output logic [13:0]                        lo_centi_ma_o,
  output logic                               hi_thr_reserved_o,
  output logic                               lo_thr_reserved_o,
  output mic_bias_diag_pkg::fault_vec_t      fault_flags_o
);
  import mic_bias_diag_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [13:0] code_to_centi(input logic [7:0] code);
    logic [13:0] diff;
    diff = {6'h00, code - `THR_CODE_MIN};
    if (code <= `THR_CODE_MIN) begin
      return 14'h0000;
    end else if (code >= `THR_CODE_MAX) begin
      return `THR_MAX_CENTI_MA;
    end else begin
      return 14'(diff * `THR_STEP_CENTI_MA);
    end
  endfunction : code_to_centi

  function automatic logic code_reserved(input logic [7:0] code);
    return (code < `THR_CODE_MIN) || (code > `THR_CODE_MAX);
  endfunction : code_reserved

  function automatic logic hit(input reg_req_t req, input logic [7:0] addr);
    return req.addr == addr;
  endfunction : hit

  // ****************************************************************
  // State
  // ****************************************************************
  bank_state_t state_q;
  bank_state_t state_d;
  fault_vec_t  events;
  fault_vec_t  flags;
  logic        latch_read;
  logic [7:0]  latch_value;

  // ****************************************************************
  // Fault detection
  // ****************************************************************
  assign events.high = meas_valid_i && (meas_code_i > state_q.hi_thr);
  assign events.low  = meas_valid_i && (meas_code_i < state_q.lo_thr);
  assign events.ov   = ov_detect_i;

  assign latch_read = req_i.rd && hit(req_i, `BIAS_FAULT_LATCH_ADDR);

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  generate
    for (genvar i = 0; i < 3; i++) begin : g_flag
      fault_flag_cell u_cell (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .event_i (events[i]),
        .clear_i (latch_read),
        .flag_o  (flags[i])
      );
    end
  endgenerate

  // ****************************************************************
  // Latch readback
  // ****************************************************************
  always_comb begin
    latch_value                              = `BIAS_FAULT_LATCH_RST;
    latch_value[`FLT_HIGH_BIT]               = flags.high;
    latch_value[`FLT_LOW_BIT]                = flags.low;
    latch_value[`FLT_OV_BIT]                 = flags.ov;
  end

  // ****************************************************************
  // Register bank
  // ****************************************************************
  always_comb begin
    state_d           = state_q;
    state_d.rsp.valid = req_i.rd;
    if (req_i.rd) begin
      unique case (req_i.addr)
        `BIAS_FAULT_LATCH_ADDR: state_d.rsp.rdata = latch_value;
        `BIAS_HIGH_LIMIT_ADDR:  state_d.rsp.rdata = state_q.hi_thr;
        `BIAS_LOW_LIMIT_ADDR:   state_d.rsp.rdata = state_q.lo_thr;
        default:                state_d.rsp.rdata = 8'h00;
      endcase
    end
    if (req_i.wr && hit(req_i, `BIAS_HIGH_LIMIT_ADDR)) begin
      state_d.hi_thr = req_i.wdata;
    end
    if (req_i.wr && hit(req_i, `BIAS_LOW_LIMIT_ADDR)) begin
      state_d.lo_thr = req_i.wdata;
    end
    state_d.hi_centi = code_to_centi(state_q.hi_thr);
    state_d.lo_centi = code_to_centi(state_q.lo_thr);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q           <= '0;
      state_q.hi_thr    <= `BIAS_HIGH_LIMIT_RST;
      state_q.lo_thr    <= `BIAS_LOW_LIMIT_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rsp_o             = state_q.rsp;
  assign hi_thr_o          = state_q.hi_thr;
  assign lo_thr_o          = state_q.lo_thr;
  assign hi_centi_ma_o     = state_q.hi_centi;
  assign lo_centi_ma_o     = state_q.lo_centi;
  assign hi_thr_reserved_o = code_reserved(state_q.hi_thr);
  assign lo_thr_reserved_o = code_reserved(state_q.lo_thr);
  assign fault_flags_o     = flags;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_HIGH_BIT_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    (latch_read && flags.high) |=> (rsp_o.valid && rsp_o.rdata[`FLT_HIGH_BIT]))
    else $error("High current fault not returned in bit 7");

  AST_LOW_BIT_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    (latch_read && !flags.low) |=> (rsp_o.valid && !rsp_o.rdata[`FLT_LOW_BIT]))
    else $error("Low current bit reads set without a fault");

  AST_OV_TO_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    (ov_detect_i && !latch_read) ##1 latch_read
      |=> rsp_o.rdata[`FLT_OV_BIT])
    else $error("Over-voltage fault not reported in bit 5");

  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    latch_read |=> (rsp_o.rdata[`FLT_RSVD_MSB:`FLT_RSVD_LSB] == 5'h00))
    else $error("Reserved latch bits read nonzero");

  AST_HIGH_SCALE: assert property (@(posedge clk_i) disable iff (reset_i)
    (hi_thr_o == 8'hf2) |=> (hi_centi_ma_o == 14'h2706))
    else $error("High threshold code 242 not 99.90 mA");

  AST_LOW_SCALE: assert property (@(posedge clk_i) disable iff (reset_i)
    (lo_thr_o == 8'h4b) |=> (lo_centi_ma_o == 14'h03cc))
    else $error("Low threshold code 75 not 9.72 mA");

  AST_HIGH_RESET: assert property (@(posedge clk_i)
    reset_i ##1 !reset_i |-> (hi_thr_o == 8'hba) ##1 (hi_centi_ma_o == 14'h1b36))
    else $error("High threshold reset value wrong");

  AST_LOW_RESET: assert property (@(posedge clk_i)
    reset_i |=> (lo_thr_o == 8'h4b))
    else $error("Low threshold reset value wrong");

  AST_HIGH_DETECT: assert property (@(posedge clk_i) disable iff (reset_i)
    (meas_valid_i && (meas_code_i > hi_thr_o)) |=> fault_flags_o.high)
    else $error("High current fault not flagged");

  AST_LOW_DETECT: assert property (@(posedge clk_i) disable iff (reset_i)
    (!meas_valid_i && !fault_flags_o.low && !latch_read) |=> !fault_flags_o.low)
    else $error("Low current flag set without a measurement");

  AST_READ_CLEARS: assert property (@(posedge clk_i) disable iff (reset_i)
    (latch_read && !meas_valid_i && !ov_detect_i) |=> (fault_flags_o == 3'b000))
    else $error("Latch read did not clear the fault flags");

  AST_WRITE_TAKES: assert property (@(posedge clk_i) disable iff (reset_i)
    (req_i.wr && req_i.addr == `BIAS_LOW_LIMIT_ADDR)
      |=> (lo_thr_o == $past(req_i.wdata)))
    else $error("Low threshold write not stored");

  AST_HIGH_WRITE_TAKES: assert property (@(posedge clk_i) disable iff (reset_i)
    (req_i.wr && req_i.addr == `BIAS_HIGH_LIMIT_ADDR)
      |=> (hi_thr_o == $past(req_i.wdata)))
    else $error("High threshold write not stored");

  AST_LOW_SET: assert property (@(posedge clk_i) disable iff (reset_i)
    (meas_valid_i && (meas_code_i < lo_thr_o)) |=> fault_flags_o.low)
    else $error("Low current fault not flagged");

  AST_OV_SET: assert property (@(posedge clk_i) disable iff (reset_i)
    ov_detect_i |=> fault_flags_o.ov)
    else $error("Over-voltage fault not flagged");

  AST_LOW_BIT_SET: assert property (@(posedge clk_i) disable iff (reset_i)
    (latch_read && flags.low) |=> (rsp_o.valid && rsp_o.rdata[`FLT_LOW_BIT]))
    else $error("Low current fault not returned in bit 6");

  AST_OV_BIT_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    (latch_read && flags.ov) |=> (rsp_o.valid && rsp_o.rdata[`FLT_OV_BIT]))
    else $error("Over-voltage fault not returned in bit 5");

  AST_LOW_CODE_OK: assert property (@(posedge clk_i) disable iff (reset_i)
    ((lo_thr_o >= 8'h39) && (lo_thr_o <= 8'hf2)) |-> !lo_thr_reserved_o)
    else $error("Usable low threshold code marked reserved");

endmodule : mic_bias_load_fault_diag

// ---- sim/tb_top.sv ----
// Self-checking bench for the bias supply fault register bank
// Assumes the bank's register port, 250 MHz clock and synchronous reset
`timescale 1ns/1ps
`include "mic_bias_diag_cfg.svh"
module tb_top;
  import mic_bias_diag_pkg::*;

  logic        clk_i;
  logic        reset_i;
  reg_req_t    req;
  reg_rsp_t    rsp;
  logic        meas_valid;
  logic [7:0]  meas_code;
  logic        ov_detect;
  logic [7:0]  hi_thr;
  logic [7:0]  lo_thr;
  logic [13:0] hi_centi;
  logic [13:0] lo_centi;
  logic        hi_res;
  logic        lo_res;
  fault_vec_t  flags;
  int          n_errors;
  int          checks;
  logic [7:0]  codes [6] = '{8'h3a, 8'h39, 8'h64, 8'hba, 8'hf2, 8'hf1};
  logic [13:0] cents [6] = '{14'h0036, 14'h0000, 14'h0912, 14'h1b36, 14'h2706, 14'h26d0};
  logic        rsvd  [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  mic_bias_load_fault_diag i_mic_bias_load_fault_diag (
    .clk_i             (clk_i),
    .reset_i           (reset_i),
    .req_i             (req),
    .rsp_o             (rsp),
    .meas_valid_i      (meas_valid),
    .meas_code_i       (meas_code),
    .ov_detect_i       (ov_detect),
    .hi_thr_o          (hi_thr),
    .lo_thr_o          (lo_thr),
    .hi_centi_ma_o     (hi_centi),
    .lo_centi_ma_o     (lo_centi),
    .hi_thr_reserved_o (hi_res),
    .lo_thr_reserved_o (lo_res),
    .fault_flags_o     (flags)
  );

  // ****************************************************************
  // Clock and helpers
  // ****************************************************************
  always #2 clk_i = ~clk_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask : wr

  // Read, then compare answer valid and data one edge later
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk_i);
    req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    chk(16'(rsp.valid), 16'h0001);
    chk(16'(rsp.rdata), 16'(exp));
  endtask : rd

  // One detector cycle, flags checked after the sampling edge
  task automatic ev(input logic [7:0] code, input logic ov, input logic [2:0] exp);
    @(posedge clk_i);
    meas_valid <= 1'b1;
    meas_code  <= code;
    ov_detect  <= ov;
    @(posedge clk_i);
    meas_valid <= 1'b0;
    ov_detect  <= 1'b0;
    #1;
    chk(16'(flags), 16'(exp));
  endtask : ev

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    req = '0;
    meas_valid = 1'b0;
    meas_code = 8'h00;
    ov_detect = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(16'(hi_centi), 16'h1b36);
    chk(16'(lo_centi), 16'h03cc);
    rd(`BIAS_HIGH_LIMIT_ADDR, `BIAS_HIGH_LIMIT_RST);
    rd(`BIAS_LOW_LIMIT_ADDR, `BIAS_LOW_LIMIT_RST);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'h00);
    wr(`BIAS_FAULT_LATCH_ADDR, 8'he0);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'h00);
    rd(8'h3a, 8'h00);
    ev(8'hba, 1'b0, 3'b000);
    ev(8'h4b, 1'b0, 3'b000);
    ev(8'hc0, 1'b0, 3'b100);
    repeat (5) @(posedge clk_i);
    #1;
    chk(16'(flags), 16'h0004);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'h80);
    chk(16'(flags), 16'h0000);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'h00);
    ev(8'h40, 1'b0, 3'b010);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'h40);
    ev(8'h80, 1'b1, 3'b001);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'h20);
    ev(8'hc0, 1'b1, 3'b101);
    ev(8'h40, 1'b0, 3'b111);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'he0);
    // Event in the read cycle keeps its flag
    ev(8'h80, 1'b1, 3'b001);
    @(posedge clk_i);
    req <= '{rd: 1'b1, wr: 1'b0, addr: `BIAS_FAULT_LATCH_ADDR, wdata: 8'h00};
    ov_detect <= 1'b1;
    @(posedge clk_i);
    req.rd <= 1'b0;
    ov_detect <= 1'b0;
    #1;
    chk(16'(rsp.rdata), 16'h0020);
    chk(16'(flags), 16'h0001);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'h20);
    // Over-voltage event read back in the very next cycle
    @(posedge clk_i);
    ov_detect <= 1'b1;
    @(posedge clk_i);
    ov_detect <= 1'b0;
    req <= '{rd: 1'b1, wr: 1'b0, addr: `BIAS_FAULT_LATCH_ADDR, wdata: 8'h00};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    chk(16'(rsp.rdata), 16'h0020);
    chk(16'(flags), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(`BIAS_HIGH_LIMIT_ADDR, codes[i]);
      wr(`BIAS_LOW_LIMIT_ADDR, codes[i]);
      @(posedge clk_i);
      #1;
      chk(16'(hi_thr), 16'(codes[i]));
      chk(16'(lo_thr), 16'(codes[i]));
      chk(16'(hi_centi), 16'(cents[i]));
      chk(16'(lo_centi), 16'(cents[i]));
      chk(16'(hi_res), 16'(rsvd[i]));
      chk(16'(lo_res), 16'(rsvd[i]));
      rd(`BIAS_HIGH_LIMIT_ADDR, codes[i]);
      rd(`BIAS_LOW_LIMIT_ADDR, codes[i]);
    end
    // Thresholds now 241: code 0x80 is below low only
    ev(8'h80, 1'b0, 3'b010);
    rd(`BIAS_FAULT_LATCH_ADDR, 8'h40);
    finish_test();
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end

endmodule : tb_top
